// File: src/key_scan_pkg.sv
// Behaviour
// - A key with zero pulse count setting is disabled, non-zero is enabled.
// - Scan one key at a time: drive lines 0..7 on receive 0, then receive 1.
// - Key index equals eight times receive index plus drive index.
// - Finish a key's burst and conversion before the next key's burst starts.
// - Burst pulse count comes from that key's own pulse count setting.
// - Disabled keys get no burst at all in the scan.
// - New frame every 16 ms; sleep once the frame's keys are all done.
// - On each drive pulse falling edge, clamp the active receive line to ground.
// - After the burst, clamp and time the ramp to zero crossing as the result.
// - Each drive pulse stays high at least 250 ns after its leading edge.
package key_scan_pkg;

  // ----------------------------------------
  // Matrix geometry and widths
  // ----------------------------------------
  localparam int KEYS  = 16;
  localparam int DRV_N = 8;
  localparam int RX_N  = 2;
  localparam int KEY_W = 4;
  localparam int DRV_W = 3;
  localparam int BL_W  = 8;
  localparam int CNT_W = 16;
  localparam int DLY_W = 8;

  localparam logic [KEY_W-1:0] LAST_KEY  = 4'hf;
  localparam logic [KEY_W-1:0] FIRST_KEY = 4'h0;
  localparam logic [BL_W-1:0]  BL_OFF    = 8'h00;
  localparam logic [CNT_W-1:0] CNT_MAX   = 16'hffff;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int DWELL_NS      = 250;
  localparam int CLAMP_NS      = 250;
  localparam int FRAME_MS      = 16;
  // Least times round up to whole cycles
  localparam int DWELL_CYC = (DWELL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CLAMP_CYC = (CLAMP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FRAME_CYC = FRAME_MS * 1000000 / CLK_PERIOD_NS;
  localparam logic [DLY_W-1:0] DWELL_LOAD = DLY_W'(DWELL_CYC - 1);
  localparam logic [DLY_W-1:0] CLAMP_LOAD = DLY_W'(CLAMP_CYC - 1);

  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_SLEEP,
    ST_SELECT,
    ST_HIGH,
    ST_LOW,
    ST_CONVERT
  } scan_state_e;

endpackage : key_scan_pkg

// File: src/pin_sync3.sv
`timescale 1ns/1ps
// Three-stage pin synchroniser; level moves once stages two and three agree
module pin_sync3
(
  input  wire logic i_core_clk,
  input  wire logic i_rst_n,
  input  wire logic i_pin,
  output logic      o_level
);
  import key_scan_pkg::*;

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic lvl_reg;
  logic lvl_next;

  // ----------------------------------------
  // Filter
  // ----------------------------------------
  // First stage feeds only the second, to keep metastability contained
  always_comb
  begin
    lvl_next = lvl_reg;
    if (s2_reg == s3_reg)
    begin
      lvl_next = s3_reg;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      s1_reg  <= 1'b0;
      s2_reg  <= 1'b0;
      s3_reg  <= 1'b0;
      lvl_reg <= 1'b0;
    end
    else
    begin
      s1_reg  <= i_pin;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      lvl_reg <= lvl_next;
    end
  end

  assign o_level = lvl_reg;

endmodule : pin_sync3

// File: src/frame_timer.sv
`timescale 1ns/1ps
// Free-running frame period counter, one-cycle tick at each wrap
module frame_timer
#(
  parameter int PERIOD = 1600000
)
(
  input  wire logic i_core_clk,
  input  wire logic i_rst_n,
  output logic      o_tick
);
  import key_scan_pkg::*;

  localparam int W = $clog2(PERIOD + 1);
  localparam logic [W-1:0] WRAP = W'(PERIOD - 1);

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic         tick_reg;
  logic         tick_next;

  // ----------------------------------------
  // Period count
  // ----------------------------------------
  always_comb
  begin
    tick_next = (cnt_reg == WRAP);
    cnt_next  = tick_next ? '0 : cnt_reg + W'(1);
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end
    else
    begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign o_tick = tick_reg;

endmodule : frame_timer

// File: src/key_matrix_burst_scanner.sv
`timescale 1ns/1ps
// Touch matrix scan sequencer: per-key bursts, clamp, zero-cross timing
module key_matrix_burst_scanner
#(
  parameter int FRAME_CYCLES = key_scan_pkg::FRAME_CYC
)
(
  input  wire logic                                           i_core_clk,
  input  wire logic                                           i_rst_n,
  input  wire logic [key_scan_pkg::KEYS-1:0][key_scan_pkg::BL_W-1:0] i_pulse_count_setting,
  input  wire logic [key_scan_pkg::RX_N-1:0]                  i_ramp_above_zero,
  output logic      [key_scan_pkg::DRV_N-1:0]                 o_drive_line,
  output logic      [key_scan_pkg::RX_N-1:0]                  o_rx_out,
  output logic      [key_scan_pkg::RX_N-1:0]                  o_rx_oe_n,
  output logic                                                o_result_valid,
  output logic      [key_scan_pkg::KEY_W-1:0]                 o_result_key,
  output logic      [key_scan_pkg::CNT_W-1:0]                 o_result_count,
  output logic                                                o_sleep
);
  import key_scan_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  scan_state_e      state_reg;
  scan_state_e      state_next;
  logic [KEY_W-1:0] key_reg;
  logic [KEY_W-1:0] key_next;
  logic [BL_W-1:0]  left_reg;
  logic [BL_W-1:0]  left_next;
  logic [DLY_W-1:0] dly_reg;
  logic [DLY_W-1:0] dly_next;
  logic [CNT_W-1:0] tmr_reg;
  logic [CNT_W-1:0] tmr_next;
  logic [DRV_N-1:0] drive_reg;
  logic [DRV_N-1:0] drive_next;
  logic [RX_N-1:0]  clamp_reg;
  logic [RX_N-1:0]  clamp_next;
  logic             valid_reg;
  logic             valid_next;
  logic [KEY_W-1:0] rkey_reg;
  logic [KEY_W-1:0] rkey_next;
  logic [CNT_W-1:0] rcnt_reg;
  logic [CNT_W-1:0] rcnt_next;
  logic             sleep_reg;
  logic             sleep_next;
  logic             frame_tick;
  logic [RX_N-1:0]  ramp_lvl;
  logic [BL_W-1:0]  cur_bl;
  logic [DRV_N-1:0] drv_hot;
  logic [RX_N-1:0]  rx_hot;
  logic             crossed;

  // ----------------------------------------
  // Frame period and pin synchronisers
  // ----------------------------------------
  frame_timer #(
    .PERIOD (FRAME_CYCLES)
  ) u_frame (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .o_tick     (frame_tick)
  );

  // Comparator outputs are asynchronous to the core clock
  for (genvar g = 0; g < RX_N; g++)
  begin : g_sync
    pin_sync3 u_sync (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .i_pin      (i_ramp_above_zero[g]),
      .o_level    (ramp_lvl[g])
    );
  end

  // ----------------------------------------
  // Key decode
  // ----------------------------------------
  // Low bits pick the drive line, top bit the receive line
  assign cur_bl  = i_pulse_count_setting[key_reg];
  assign drv_hot = DRV_N'(1) << key_reg[DRV_W-1:0];
  assign rx_hot  = RX_N'(1) << key_reg[KEY_W-1];
  assign crossed = ramp_lvl[key_reg[KEY_W-1]];

  // ----------------------------------------
  // Sequencer next state
  // ----------------------------------------
  // Outputs are computed one cycle ahead so they leave straight from flops
  always_comb
  begin
    state_next = state_reg;
    key_next   = key_reg;
    left_next  = left_reg;
    dly_next   = (dly_reg != '0) ? dly_reg - DLY_W'(1) : dly_reg;
    tmr_next   = '0;
    drive_next = '0;
    clamp_next = '0;
    valid_next = 1'b0;
    rkey_next  = rkey_reg;
    rcnt_next  = rcnt_reg;
    case (state_reg)
      ST_SLEEP:
      begin
        // A tick while busy is dropped; the frame resumes on the next one
        if (frame_tick)
        begin
          key_next   = FIRST_KEY;
          state_next = ST_SELECT;
        end
      end
      ST_SELECT:
      begin
        if (cur_bl != BL_OFF)
        begin
          left_next  = cur_bl;
          dly_next   = DWELL_LOAD;
          drive_next = drv_hot;
          state_next = ST_HIGH;
        end
        else if (key_reg == LAST_KEY)
        begin
          state_next = ST_SLEEP;
        end
        else
        begin
          key_next = key_reg + KEY_W'(1);
        end
      end
      ST_HIGH:
      begin
        // Held for the full dwell so charge is captured after slow edges
        if (dly_reg == '0)
        begin
          clamp_next = rx_hot;
          dly_next   = CLAMP_LOAD;
          left_next  = left_reg - BL_W'(1);
          state_next = ST_LOW;
        end
        else
        begin
          drive_next = drv_hot;
        end
      end
      ST_LOW:
      begin
        if (dly_reg != '0)
        begin
          clamp_next = rx_hot;
        end
        else if (left_reg == BL_OFF)
        begin
          // Clamp stays on and the timer starts from zero
          clamp_next = rx_hot;
          state_next = ST_CONVERT;
        end
        else
        begin
          dly_next   = DWELL_LOAD;
          drive_next = drv_hot;
          state_next = ST_HIGH;
        end
      end
      ST_CONVERT:
      begin
        if (crossed || tmr_reg == CNT_MAX)
        begin
          valid_next = 1'b1;
          rkey_next  = key_reg;
          rcnt_next  = tmr_reg;
          if (key_reg == LAST_KEY)
          begin
            state_next = ST_SLEEP;
          end
          else
          begin
            key_next   = key_reg + KEY_W'(1);
            state_next = ST_SELECT;
          end
        end
        else
        begin
          clamp_next = rx_hot;
          tmr_next   = tmr_reg + CNT_W'(1);
        end
      end
      default:
      begin
        state_next = ST_SLEEP;
      end
    endcase
    sleep_next = (state_next == ST_SLEEP);
  end

  // ----------------------------------------
  // Sequencer registers
  // ----------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_reg <= ST_SLEEP;
      key_reg   <= FIRST_KEY;
      left_reg  <= BL_OFF;
      dly_reg   <= '0;
      tmr_reg   <= '0;
      drive_reg <= '0;
      clamp_reg <= '0;
      valid_reg <= 1'b0;
      rkey_reg  <= FIRST_KEY;
      rcnt_reg  <= '0;
      sleep_reg <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
      key_reg   <= key_next;
      left_reg  <= left_next;
      dly_reg   <= dly_next;
      tmr_reg   <= tmr_next;
      drive_reg <= drive_next;
      clamp_reg <= clamp_next;
      valid_reg <= valid_next;
      rkey_reg  <= rkey_next;
      rcnt_reg  <= rcnt_next;
      sleep_reg <= sleep_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Receive pins only ever pull to ground; enable is active low
  assign o_drive_line   = drive_reg;
  assign o_rx_out       = '0;
  assign o_rx_oe_n      = ~clamp_reg;
  assign o_result_valid = valid_reg;
  assign o_result_key   = rkey_reg;
  assign o_result_count = rcnt_reg;
  assign o_sleep        = sleep_reg;

  // ----------------------------------------
  // Checking helpers
  // ----------------------------------------
  logic [DLY_W-1:0] hi_len_reg;
  logic [BL_W-1:0]  pulses_reg;
  logic [KEY_W-1:0] last_key_reg;
  logic             any_result_reg;
  localparam int DWELL_MIN = DWELL_CYC;

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      hi_len_reg     <= '0;
      pulses_reg     <= '0;
      last_key_reg   <= FIRST_KEY;
      any_result_reg <= 1'b0;
    end
    else
    begin
      hi_len_reg     <= (drive_reg != '0) ? hi_len_reg + DLY_W'(1) : '0;
      // A pulse starts where drive is high and the high-time count is still zero
      pulses_reg     <= (state_reg == ST_SELECT) ? '0 :
                        (((drive_reg != '0) && (hi_len_reg == '0)) ? pulses_reg + BL_W'(1) : pulses_reg);
      if (valid_reg)
      begin
        last_key_reg   <= rkey_reg;
        any_result_reg <= 1'b1;
      end
      if (state_reg == ST_SLEEP)
      begin
        any_result_reg <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  sequence seq_pulse_end;
    $fell(|drive_reg);
  endsequence

  sequence seq_clamped;
    clamp_reg == rx_hot;
  endsequence

  AST_DISABLED_NO_BURST:
    assert property ((state_reg == ST_SELECT && cur_bl == BL_OFF) |=> drive_reg == '0)
    else $error("disabled key was driven");

  AST_ONE_DRIVE_LINE:
    assert property ($onehot0(drive_reg))
    else $error("more than one drive line high");

  AST_KEY_MAPPING:
    assert property ((drive_reg != '0) |-> (drive_reg == drv_hot && state_reg == ST_HIGH))
    else $error("drive line does not match key index");

  AST_NO_DRIVE_IN_CONVERT:
    assert property ((state_reg == ST_CONVERT) |-> (drive_reg == '0 && clamp_reg == rx_hot))
    else $error("burst overlaps conversion");

  AST_BURST_LENGTH:
    assert property (valid_reg |-> pulses_reg == i_pulse_count_setting[rkey_reg])
    else $error("pulse count differs from setting");

  AST_KEY_ORDER:
    assert property ((valid_reg && any_result_reg) |-> rkey_reg > last_key_reg)
    else $error("keys not scanned in ascending order");

  AST_SLEEP_QUIET:
    assert property (sleep_reg |-> (drive_reg == '0 && clamp_reg == '0 && tmr_reg == '0))
    else $error("activity during sleep");

  AST_CLAMP_ON_FALL:
    assert property (seq_pulse_end |-> seq_clamped ##1 (clamp_reg == rx_hot))
    else $error("receive line not clamped after pulse");

  AST_RESULT_IS_TIMER:
    assert property ((state_reg == ST_CONVERT && crossed) |=> (valid_reg && rcnt_reg == $past(tmr_reg)))
    else $error("result is not the crossing time");

  AST_DWELL_TIME:
    assert property (seq_pulse_end |-> hi_len_reg >= DLY_W'(DWELL_MIN))
    else $error("drive pulse shorter than dwell");

  AST_TIMER_IDLE_ZERO:
    assert property ((state_reg != ST_CONVERT) |-> tmr_reg == '0)
    else $error("timer not zero between conversions");

endmodule : key_matrix_burst_scanner

// File: tb/electrode_model.sv
`timescale 1ns/1ps
// Electrode pair and sample capacitor behind the receive pins
module electrode_model
#(
  parameter int SCALE = 10
)
(
  input  wire logic                            i_core_clk,
  input  wire logic [key_scan_pkg::DRV_N-1:0]  i_drive_line,
  input  wire logic [key_scan_pkg::RX_N-1:0]   i_rx_out,
  input  wire logic [key_scan_pkg::RX_N-1:0]   i_rx_oe_n,
  input  wire logic                            i_stuck,
  output logic      [key_scan_pkg::RX_N-1:0]   o_ramp_above_zero
);
  import key_scan_pkg::*;

  logic [DRV_N-1:0] drive_reg = '0;
  logic [RX_N-1:0]  grounded;
  int               pulse_reg = 0;
  int               clamp_reg [RX_N];

  // --------------------------------
  // Pin level and charge tally
  // --------------------------------
  // Pin sits at ground only while its driver is enabled and low
  assign grounded = ~i_rx_oe_n & ~i_rx_out;

  // Pulses add charge; a fully idle matrix empties the capacitor
  always @(posedge i_core_clk)
  begin
    drive_reg <= i_drive_line;
    if (i_drive_line != '0 && drive_reg == '0)
      pulse_reg <= pulse_reg + 1;
    else if (i_drive_line == '0 && grounded == '0)
      pulse_reg <= 0;
    for (int r = 0; r < RX_N; r++)
      clamp_reg[r] <= (grounded[r] && i_drive_line == '0) ? clamp_reg[r] + 1 : 0;
  end

  // Ramp needs longer with more charge; stuck models a ramp that never crosses
  always_comb
  begin
    for (int r = 0; r < RX_N; r++)
      if (!(grounded[r] && i_drive_line == '0))
        o_ramp_above_zero[r] = 1'b1;
      else
        o_ramp_above_zero[r] = !i_stuck && (clamp_reg[r] >= 25 + SCALE * pulse_reg);
  end
endmodule : electrode_model

// File: tb/key_matrix_burst_scanner_bench.sv
`timescale 1ns/1ps
// Self-checking bench for the key matrix burst scanner
module key_matrix_burst_scanner_bench;
  import key_scan_pkg::*;

  localparam int FRAME = 3000;
  localparam int SCALE = 10;

  logic                      core_clk = 1'b0;
  logic                      rst_n    = 1'b0;
  logic                      stuck    = 1'b0;
  logic [KEYS-1:0][BL_W-1:0] setting  = '0;
  logic [RX_N-1:0]           ramp;
  logic [DRV_N-1:0]          drive;
  logic [DRV_N-1:0]          drive_prev = '0;
  logic [DRV_N-1:0]          last_drive = '0;
  logic [RX_N-1:0]           rx_out;
  logic [RX_N-1:0]           rx_oe_n;
  logic [RX_N-1:0]           last_oe    = '1;
  logic                      valid;
  logic                      sleep;
  logic [KEY_W-1:0]          rkey;
  logic [CNT_W-1:0]          rcount;
  int                        fails = 0;
  int                        checks = 0;
  int                        rise_cnt = 0;
  int                        high_len = 0;
  int                        cyc = 0;
  logic [KEY_W-1:0]          q_key[$];
  logic [CNT_W-1:0]          q_count[$];
  logic [DRV_N-1:0]          q_line[$];
  logic [RX_N-1:0]           q_oe[$];
  int                        q_pulse[$];

  always #5 core_clk = ~core_clk;

  key_matrix_burst_scanner #(.FRAME_CYCLES(FRAME)) key_matrix_burst_scanner_i (
    .i_core_clk(core_clk), .i_rst_n(rst_n), .i_pulse_count_setting(setting),
    .i_ramp_above_zero(ramp), .o_drive_line(drive), .o_rx_out(rx_out), .o_rx_oe_n(rx_oe_n),
    .o_result_valid(valid), .o_result_key(rkey), .o_result_count(rcount), .o_sleep(sleep));

  electrode_model #(.SCALE(SCALE)) electrode_model_i (
    .i_core_clk(core_clk), .i_drive_line(drive), .i_rx_out(rx_out), .i_rx_oe_n(rx_oe_n),
    .i_stuck(stuck), .o_ramp_above_zero(ramp));

  // --------------------------------
  // Compare helpers and closing
  // --------------------------------
  task automatic compare_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : compare_val

  // Ramp time includes synchroniser latency, so only a window is known
  task automatic compare_range(input string what, input int lo, input int hi, input logic [31:0] got);
    checks++;
    if (!(got >= lo && got <= hi) || $isunknown(got))
    begin
      fails++;
      $display("Error %s expected %0d..%0d seen %h", what, lo, hi, got);
    end
  endtask : compare_range

  task automatic wrap_up;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  // --------------------------------
  // Link monitor
  // --------------------------------
  // Watches every pulse so scenarios only judge the collected results
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    drive_prev <= drive;
    if (drive != '0)
      high_len <= high_len + 1;
    if (drive != '0 && drive_prev == '0)
    begin
      rise_cnt <= rise_cnt + 1;
      last_drive <= drive;
    end
    if (drive == '0 && drive_prev != '0)
    begin
      high_len <= 0;
      last_oe <= rx_oe_n;
      compare_val("pulse_width", DWELL_CYC, high_len);
      compare_val("clamp_on_fall", 1, rx_oe_n != 2'b11);
    end
    if (valid === 1'b1)
    begin
      q_key.push_back(rkey);
      q_count.push_back(rcount);
      q_line.push_back(last_drive);
      q_oe.push_back(last_oe);
      q_pulse.push_back(rise_cnt);
      rise_cnt <= 0;
    end
  end

  // Bounded wait for the sleep flag to reach a level
  task automatic wait_sleep(input logic lvl);
    int n;
    n = 0;
    while (sleep !== lvl && n < 90000)
    begin
      @(posedge core_clk);
      n++;
    end
    compare_val("sleep_wait", lvl, sleep);
  endtask : wait_sleep

  // --------------------------------
  // Scenarios
  // --------------------------------
  task automatic t_reset;
    compare_val("reset_drive", 0, drive);
    compare_val("reset_oe_n", 2'b11, rx_oe_n);
    compare_val("reset_valid", 0, valid);
    compare_val("reset_sleep", 1, sleep);
    compare_val("reset_rx_out", 0, rx_out);
  endtask : t_reset

  // One frame with the given settings; results judged against them
  task automatic run_frame(input logic [KEYS-1:0][BL_W-1:0] s);
    int n;
    logic [RX_N-1:0] exp_oe;
    n = 0;
    wait_sleep(1'b1);
    setting <= s;
    wait_sleep(1'b0);
    q_key.delete();
    q_count.delete();
    q_line.delete();
    q_oe.delete();
    q_pulse.delete();
    wait_sleep(1'b1);
    // Last result lands with sleep; let the monitor store it first
    @(posedge core_clk);
    for (int i = 0; i < KEYS; i++)
      if (s[i] != BL_OFF)
      begin
        compare_val("key", i, q_key[n]);
        compare_val("drive_line", 8'h01 << i[2:0], q_line[n]);
        exp_oe = ~(RX_N'(1) << i[3]);
        compare_val("clamp_line", exp_oe, q_oe[n]);
        compare_val("pulses", s[i], q_pulse[n]);
        if (stuck)
          compare_val("count", CNT_MAX, q_count[n]);
        else
          compare_range("count", SCALE * s[i] - 2, SCALE * s[i] + 8, q_count[n]);
        n++;
      end
    compare_val("results", n, q_key.size());
  endtask : run_frame

  task automatic t_full_scan;
    logic [KEYS-1:0][BL_W-1:0] s;
    for (int i = 0; i < KEYS; i++)
      s[i] = BL_W'(i % 3 + 1);
    run_frame(s);
  endtask : t_full_scan

  task automatic t_sparse;
    logic [KEYS-1:0][BL_W-1:0] s;
    s = '0;
    s[7] = 8'h05;
    s[8] = 8'h01;
    s[15] = 8'h0c;
    run_frame(s);
  endtask : t_sparse

  // Two frame starts in a row are one period apart
  task automatic t_frame_period;
    int t0;
    wait_sleep(1'b0);
    t0 = cyc;
    wait_sleep(1'b1);
    wait_sleep(1'b0);
    compare_val("frame_period", FRAME, cyc - t0);
  endtask : t_frame_period

  task automatic t_saturate;
    logic [KEYS-1:0][BL_W-1:0] s;
    s = '0;
    s[9] = 8'h02;
    wait_sleep(1'b1);
    stuck <= 1'b1;
    run_frame(s);
    stuck <= 1'b0;
  endtask : t_saturate

  // --------------------------------
  // Main sequence and watchdog
  // --------------------------------
  initial
  begin
    repeat (3) @(posedge core_clk);
    t_reset();
    rst_n <= 1'b1;
    t_full_scan();
    t_sparse();
    t_frame_period();
    t_saturate();
    t_full_scan();
    wrap_up();
  end

  // Sized for a few frames plus one saturated conversion
  initial
  begin
    repeat (100000) @(posedge core_clk);
    fails++;
    wrap_up();
  end
endmodule : key_matrix_burst_scanner_bench
